// >>> hw/strap_regs.svh
/*
 * Offsets, field positions, reset values and strap codes of the
 * clock ratio strap decoder.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef STRAP_REGS_SVH
`define STRAP_REGS_SVH

// register byte offsets
`define STATUS_ADDR      8'h00
`define CONTROL_ADDR     8'h04
`define TICKS_ADDR       8'h08

// status fields
`define ST_PLAT_CODE_LSB 0
`define ST_CORE_CODE_LSB 4
`define ST_PCI64_BIT     6
`define ST_VALID_BIT     7
`define ST_UNSUP_BIT     8
`define ST_PLAT_MULT_LSB 16
`define ST_CORE_HALF_LSB 24

// control fields and reset value
`define CTL_TICK_EN_BIT  0
`define CTL_RESET        1'b0

// platform ratio strap codes with a ratio
`define PLAT_CODE_16     4'h0
`define PLAT_CODE_2      4'h2
`define PLAT_CODE_6      4'h6
`define PLAT_CODE_8      4'h8
`define PLAT_CODE_9      4'h9
`define PLAT_CODE_10     4'ha
`define PLAT_CODE_12     4'hc
`define PLAT_MULT_16     5'h10
`define PLAT_MULT_12     5'h0c
`define PLAT_MULT_NONE   5'h00

// core ratio in half steps: 4/2, 5/2, 6/2, 7/2
`define CORE_HALF_00     3'h4
`define CORE_HALF_01     3'h5
`define CORE_HALF_10     3'h6
`define CORE_HALF_11     3'h7

`endif

// >>> hw/strap_pkg.sv
/*
 * Types shared by the strap decoder modules.
 * Assumes the constants header is compiled alongside.
 */
package strap_pkg;
	typedef logic [3:0] plat_code_type;
	typedef logic [1:0] core_code_type;
	typedef logic [4:0] plat_mult_type;
	typedef logic [2:0] core_half_type;
	typedef enum logic [1:0] {st_wait, st_capture, st_locked} capture_state_type;
endpackage

// >>> hw/strap_if.sv
/*
 * Carries captured strap codes to the ratio decoder and its results back.
 * Assumes one decoder and one user on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
	strap_pkg::plat_code_type plat_code;
	strap_pkg::core_code_type core_code;
	strap_pkg::plat_mult_type plat_mult;
	strap_pkg::core_half_type core_half;
	logic                     unsupported;

	modport decoder (input plat_code, input core_code,
		output plat_mult, output core_half, output unsupported);
	modport user (output plat_code, output core_code,
		input plat_mult, input core_half, input unsupported);
endinterface
`default_nettype wire

// >>> hw/ratio_decode.sv
/*
 * Pure decode of captured strap codes into clock ratios.
 * Assumes its codes come from stable capture registers.
 */
`timescale 1ns/1ps
`default_nettype none
`include "strap_regs.svh"
module ratio_decode (
	// codes in, ratios out
	strap_if.decoder port
);
	always_comb begin
		port.unsupported = 1'b0;
		case (port.plat_code)
			`PLAT_CODE_16: port.plat_mult = `PLAT_MULT_16;
			`PLAT_CODE_8, `PLAT_CODE_9, `PLAT_CODE_10:
				port.plat_mult = {1'b0, port.plat_code};
			`PLAT_CODE_12: port.plat_mult = `PLAT_MULT_12;
			default: begin
				if (port.plat_code >= `PLAT_CODE_2 && port.plat_code <= `PLAT_CODE_6) begin
					port.plat_mult = {1'b0, port.plat_code};
				end else begin
					// reserved codes give no ratio at all
					port.plat_mult   = `PLAT_MULT_NONE;
					port.unsupported = 1'b1;
				end
			end
		endcase
	end

	always_comb begin
		case (port.core_code)
			2'b00:   port.core_half = `CORE_HALF_00;
			2'b01:   port.core_half = `CORE_HALF_01;
			2'b10:   port.core_half = `CORE_HALF_10;
			default: port.core_half = `CORE_HALF_11;
		endcase
	end
endmodule // ratio_decode
`default_nettype wire

// >>> hw/clock_ratio_strap_decoder.sv
/*
 * Reset-time strap capture and clock ratio decode, with a Wishbone
 * classic register slave and a system-clock reference tick.
 * Assumes clock is the platform clock and all pins are synchronous to it.
 */
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "strap_regs.svh"
module clock_ratio_strap_decoder (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// hard reset pin
	input  wire logic        hard_reset_n,
	// strap pins
	input  wire logic [3:0]  platform_ratio_strap,
	input  wire logic        core_ratio_strap_high,
	input  wire logic        core_ratio_strap_low,
	input  wire logic        pci_width_strap,
	// pin control
	output logic             cfg_pullup_en,
	output logic             cfg_ready_out,
	output logic             cfg_ready_oe,
	// decoded ratios
	output logic [4:0]       platform_mult,
	output logic [2:0]       core_half_ratio,
	output logic             ratio_unsupported,
	output logic             pci_64bit,
	output logic             ratios_valid,
	output logic             sys_ref_tick,
	// wishbone slave
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_cyc_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o
);
	strap_if dec_if ();

	// capture state
	strap_pkg::capture_state_type state_r;
	strap_pkg::capture_state_type state_nxt;
	strap_pkg::plat_code_type     plat_code_r;
	strap_pkg::plat_code_type     plat_code_nxt;
	strap_pkg::core_code_type     core_code_r;
	strap_pkg::core_code_type     core_code_nxt;
	logic                         pci64_r;
	logic                         pci64_nxt;
	logic                         valid_r;
	logic                         valid_nxt;

	// pin control state
	logic                         pullup_r;
	logic                         pullup_nxt;
	logic                         ready_r;
	logic                         ready_nxt;
	logic                         oe_r;
	logic                         oe_nxt;

	// decoded outputs
	strap_pkg::plat_mult_type     mult_r;
	strap_pkg::plat_mult_type     mult_nxt;
	strap_pkg::core_half_type     half_r;
	strap_pkg::core_half_type     half_nxt;
	logic                         unsup_r;
	logic                         unsup_nxt;

	// reference tick divider
	logic                         tick_en_r;
	logic                         tick_en_nxt;
	logic [4:0]                   div_r;
	logic [4:0]                   div_nxt;
	logic                         tick_r;
	logic                         tick_nxt;
	logic [31:0]                  ticks_r;
	logic [31:0]                  ticks_nxt;
	logic                         tick_run;

	// bus state
	logic [31:0]                  rdata_r;
	logic [31:0]                  rdata_nxt;
	logic                         ack_r;
	logic                         ack_nxt;
	logic                         bus_req;

	assign dec_if.plat_code = plat_code_r;
	assign dec_if.core_code = core_code_r;

	ratio_decode u_decode (
		.port (dec_if.decoder)
	);

	always_comb begin
		state_nxt     = state_r;
		plat_code_nxt = plat_code_r;
		core_code_nxt = core_code_r;
		pci64_nxt     = pci64_r;
		valid_nxt     = valid_r;
		case (state_r)
			strap_pkg::st_wait: begin
				// nothing to trust until the pin shows a reset
				if (!hard_reset_n) begin
					state_nxt = strap_pkg::st_capture;
				end
			end
			strap_pkg::st_capture: begin
				// keep sampling; the sample taken on the clock that sees release wins
				plat_code_nxt = platform_ratio_strap;
				core_code_nxt = {core_ratio_strap_high, core_ratio_strap_low};
				pci64_nxt     = ~pci_width_strap;
				valid_nxt     = 1'b0;
				if (hard_reset_n) begin
					state_nxt = strap_pkg::st_locked;
					valid_nxt = 1'b1;
				end
			end
			strap_pkg::st_locked: begin
				// straps ignored here; only a new hard reset recaptures
				if (!hard_reset_n) begin
					state_nxt = strap_pkg::st_capture;
				end
			end
			default: begin
				// an illegal state waits for a fresh hard reset
				state_nxt = strap_pkg::st_wait;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r     <= strap_pkg::st_wait;
			plat_code_r <= 4'h0;
			core_code_r <= 2'h0;
			pci64_r     <= 1'b0;
			valid_r     <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			plat_code_r <= plat_code_nxt;
			core_code_r <= core_code_nxt;
			pci64_r     <= pci64_nxt;
			valid_r     <= valid_nxt;
		end
	end

	always_comb begin
		// pull-up follows reset; lags the pin by one clock
		pullup_nxt = ~hard_reset_n;
		ready_nxt  = valid_nxt;
		// ready pin stays driven, reset included, so the board never sees it float
		oe_nxt     = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pullup_r <= 1'b1;
			ready_r  <= 1'b0;
			oe_r     <= 1'b1;
		end else begin
			pullup_r <= pullup_nxt;
			ready_r  <= ready_nxt;
			oe_r     <= oe_nxt;
		end
	end

	always_comb begin
		// registered so the pins never show decoder glitches
		mult_nxt  = dec_if.plat_mult;
		half_nxt  = dec_if.core_half;
		unsup_nxt = dec_if.unsupported;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mult_r  <= 5'h00;
			half_r  <= 3'h0;
			unsup_r <= 1'b0;
		end else begin
			mult_r  <= mult_nxt;
			half_r  <= half_nxt;
			unsup_r <= unsup_nxt;
		end
	end

	// divider step, shared by the compare and the count
	function automatic strap_pkg::plat_mult_type div_step(input strap_pkg::plat_mult_type d);
		return d + 5'h01;
	endfunction

	// a reserved ratio has no period to count, so the divider stays parked
	assign tick_run = tick_en_r & valid_r & ~unsup_r;

	always_comb begin
		div_nxt   = div_r;
		tick_nxt  = 1'b0;
		ticks_nxt = ticks_r;
		// no tick without a locked, supported ratio
		if (!tick_run) begin
			div_nxt = 5'h00;
		end else if (div_step(div_r) >= mult_r) begin
			// platform clock runs mult times the system input clock
			div_nxt   = 5'h00;
			tick_nxt  = 1'b1;
			// count wraps silently after 2^32 pulses
			ticks_nxt = ticks_r + 32'h00000001;
		end else begin
			div_nxt = div_step(div_r);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_r   <= 5'h00;
			tick_r  <= 1'b0;
			ticks_r <= 32'h00000000;
		end else begin
			div_r   <= div_nxt;
			tick_r  <= tick_nxt;
			ticks_r <= ticks_nxt;
		end
	end

	// ack blocks a second take while the master still holds the same request
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;

	always_comb begin
		ack_nxt     = bus_req;
		rdata_nxt   = rdata_r;
		tick_en_nxt = tick_en_r;
		// read data moves only on a taken request and holds until the next
		if (bus_req) begin
			rdata_nxt = 32'h00000000;
			case (wb_adr_i)
				`STATUS_ADDR: begin
					rdata_nxt[`ST_PLAT_CODE_LSB +: 4] = plat_code_r;
					rdata_nxt[`ST_CORE_CODE_LSB +: 2] = core_code_r;
					rdata_nxt[`ST_PCI64_BIT]          = pci64_r;
					rdata_nxt[`ST_VALID_BIT]          = valid_r;
					rdata_nxt[`ST_UNSUP_BIT]          = unsup_r;
					rdata_nxt[`ST_PLAT_MULT_LSB +: 5] = mult_r;
					rdata_nxt[`ST_CORE_HALF_LSB +: 3] = half_r;
				end
				`CONTROL_ADDR: begin
					rdata_nxt[`CTL_TICK_EN_BIT] = tick_en_r;
					if (wb_we_i && wb_sel_i[0]) begin
						tick_en_nxt = wb_dat_i[`CTL_TICK_EN_BIT];
					end
				end
				`TICKS_ADDR: begin
					rdata_nxt = ticks_r;
				end
				default: begin
					// unmapped: acknowledged, reads zero, writes dropped
					rdata_nxt = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ack_r     <= 1'b0;
			rdata_r   <= 32'h00000000;
			tick_en_r <= `CTL_RESET;
		end else begin
			ack_r     <= ack_nxt;
			rdata_r   <= rdata_nxt;
			tick_en_r <= tick_en_nxt;
		end
	end

	// every output below is a plain flop
	assign cfg_pullup_en     = pullup_r;
	assign cfg_ready_out     = ready_r;
	assign cfg_ready_oe      = oe_r;
	assign platform_mult     = mult_r;
	assign core_half_ratio   = half_r;
	assign ratio_unsupported = unsup_r;
	assign pci_64bit         = pci64_r;
	assign ratios_valid      = valid_r;
	assign sys_ref_tick      = tick_r;
	assign wb_dat_o          = rdata_r;
	assign wb_ack_o          = ack_r;
endmodule // clock_ratio_strap_decoder
`default_nettype wire

// >>> bench/strap_chk_asserts.sv
/* Port checker for the strap decoder.
 * Assumes one clock and a bind to the top module. */
`timescale 1ns/1ps
`default_nettype none
module strap_chk (
	// clock and reset
	input wire logic       clock,
	input wire logic       sys_rst,
	// pins
	input wire logic       hard_reset_n,
	input wire logic [3:0] platform_ratio_strap,
	input wire logic       core_ratio_strap_high,
	input wire logic       core_ratio_strap_low,
	input wire logic       pci_width_strap,
	// results
	input wire logic       cfg_pullup_en,
	input wire logic       cfg_ready_oe,
	input wire logic [4:0] platform_mult,
	input wire logic [2:0] core_half_ratio,
	input wire logic       ratio_unsupported,
	input wire logic       pci_64bit,
	input wire logic       ratios_valid,
	// bus
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	function automatic logic [4:0] mult_of(logic [3:0] c);
		if (c == 4'h0)
			return 5'h10;
		return (c inside {[4'h2:4'h6], 4'h8, 4'h9, 4'ha, 4'hc}) ? {1'b0, c} : 5'h00;
	endfunction
	a_pullup_in_reset: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
		|-> cfg_pullup_en == !$past(hard_reset_n)) else $error("pull-up enable wrong");
	a_pin_driven: assert property (cfg_ready_oe) else $error("ready pin floated");
	a_plat_decode: assert property ($rose(ratios_valid) |=>
		platform_mult == mult_of($past(platform_ratio_strap, 2))) else $error("bad ratio");
	a_reserved_flag: assert property ($rose(ratios_valid) |=> ratio_unsupported ==
		(mult_of($past(platform_ratio_strap, 2)) == 5'h00)) else $error("bad reserved flag");
	a_core_decode: assert property ($rose(ratios_valid) |=> core_half_ratio ==
		{1'b1, $past(core_ratio_strap_high, 2), $past(core_ratio_strap_low, 2)})
		else $error("bad core ratio");
	a_pci_width: assert property ($rose(ratios_valid) |=>
		pci_64bit == !$past(pci_width_strap, 2)) else $error("bad pci width");
	a_codes_held: assert property (ratios_valid[*3] |-> $stable(platform_mult)
		&& $stable(core_half_ratio) && $stable(pci_64bit)) else $error("ratio moved");
	a_valid_drops: assert property (ratios_valid && !hard_reset_n |-> ##[1:2] !ratios_valid)
		else $error("valid kept in hard reset");
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	c_reserved: cover property ($rose(ratio_unsupported));
	c_recapture: cover property ($fell(ratios_valid));
	c_sixteen: cover property (platform_mult == 5'h10);
endmodule // strap_chk
bind clock_ratio_strap_decoder strap_chk i_strap_chk (
	.clock                 (clock),
	.sys_rst               (sys_rst),
	.hard_reset_n          (hard_reset_n),
	.platform_ratio_strap  (platform_ratio_strap),
	.core_ratio_strap_high (core_ratio_strap_high),
	.core_ratio_strap_low  (core_ratio_strap_low),
	.pci_width_strap       (pci_width_strap),
	.cfg_pullup_en         (cfg_pullup_en),
	.cfg_ready_oe          (cfg_ready_oe),
	.platform_mult         (platform_mult),
	.core_half_ratio       (core_half_ratio),
	.ratio_unsupported     (ratio_unsupported),
	.pci_64bit             (pci_64bit),
	.ratios_valid          (ratios_valid),
	.wb_cyc_i              (wb_cyc_i),
	.wb_stb_i              (wb_stb_i),
	.wb_ack_o              (wb_ack_o)
);
`default_nettype wire

// >>> bench/strap_board.sv
/* Board side of the strap pins: sets a code and pulses hard reset.
 * Assumes go is a one-cycle pulse given while busy is low. */
`timescale 1ns/1ps
`default_nettype none
module strap_board (
	// request from the bench
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic [3:0] plat_code,
	input  wire logic [1:0] core_code,
	input  wire logic       wide_pci,
	input  wire logic [3:0] low_len,
	// board pins
	output logic            hard_reset_n,
	output logic [3:0]      platform_ratio_strap,
	output logic            core_ratio_strap_high,
	output logic            core_ratio_strap_low,
	output logic            pci_width_strap,
	output logic            busy
);
	initial begin
		hard_reset_n = 1'b1;
		busy = 1'b0;
		{platform_ratio_strap, core_ratio_strap_high, core_ratio_strap_low} = 6'h15;
		pci_width_strap = 1'b0;
	end
	always @(posedge clock) begin
		if (go && !busy) begin
			busy <= 1'b1;
			hard_reset_n <= 1'b0;
			// actively driven: no default ratio to fall back on
			platform_ratio_strap <= plat_code;
			{core_ratio_strap_high, core_ratio_strap_low} <= core_code;
			pci_width_strap <= !wide_pci;
			repeat (4 + low_len) @(posedge clock);
			hard_reset_n <= 1'b1;
			repeat (2) @(posedge clock);
			// hold time over, so the pins wander
			{platform_ratio_strap, core_ratio_strap_high, core_ratio_strap_low} <=
				~{platform_ratio_strap, core_ratio_strap_high, core_ratio_strap_low};
			pci_width_strap <= !pci_width_strap;
			busy <= 1'b0;
		end
	end
endmodule // strap_board
`default_nettype wire

// >>> bench/tb_clock_ratio_strap_decoder.sv
/* Self-checking bench for the strap decoder.
 * Assumes the board model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "strap_regs.svh"
module tb_clock_ratio_strap_decoder;
	logic        clock, sys_rst, go, wide_pci, busy, hard_reset_n;
	logic        core_ratio_strap_high, core_ratio_strap_low, pci_width_strap;
	logic        cfg_pullup_en, cfg_ready_out, cfg_ready_oe, ratio_unsupported;
	logic        pci_64bit, ratios_valid, sys_ref_tick, wb_we_i, wb_stb_i;
	logic        wb_cyc_i, wb_ack_o;
	logic [1:0]  core_code;
	logic [2:0]  core_half_ratio;
	logic [3:0]  platform_ratio_strap, plat_code, low_len, wb_sel_i;
	logic [4:0]  platform_mult;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, t;
	int          n_mismatch, compares;
	clock_ratio_strap_decoder i_clock_ratio_strap_decoder (
		.clock                 (clock),
		.sys_rst               (sys_rst),
		.hard_reset_n          (hard_reset_n),
		.platform_ratio_strap  (platform_ratio_strap),
		.core_ratio_strap_high (core_ratio_strap_high),
		.core_ratio_strap_low  (core_ratio_strap_low),
		.pci_width_strap       (pci_width_strap),
		.cfg_pullup_en         (cfg_pullup_en),
		.cfg_ready_out         (cfg_ready_out),
		.cfg_ready_oe          (cfg_ready_oe),
		.platform_mult         (platform_mult),
		.core_half_ratio       (core_half_ratio),
		.ratio_unsupported     (ratio_unsupported),
		.pci_64bit             (pci_64bit),
		.ratios_valid          (ratios_valid),
		.sys_ref_tick          (sys_ref_tick),
		.wb_adr_i              (wb_adr_i),
		.wb_dat_i              (wb_dat_i),
		.wb_sel_i              (wb_sel_i),
		.wb_we_i               (wb_we_i),
		.wb_stb_i              (wb_stb_i),
		.wb_cyc_i              (wb_cyc_i),
		.wb_dat_o              (wb_dat_o),
		.wb_ack_o              (wb_ack_o)
	);
	strap_board i_strap_board (
		.clock                 (clock),
		.go                    (go),
		.plat_code             (plat_code),
		.core_code             (core_code),
		.wide_pci              (wide_pci),
		.low_len               (low_len),
		.hard_reset_n          (hard_reset_n),
		.platform_ratio_strap  (platform_ratio_strap),
		.core_ratio_strap_high (core_ratio_strap_high),
		.core_ratio_strap_low  (core_ratio_strap_low),
		.pci_width_strap       (pci_width_strap),
		.busy                  (busy)
	);
	task automatic check(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [4:0] mult_of(input logic [3:0] c);
		if (c == 4'h0)
			return 5'h10;
		return (c inside {[4'h2:4'h6], 4'h8, 4'h9, 4'ha, 4'hc}) ? {1'b0, c} : 5'h00;
	endfunction
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		int k;
		@(posedge clock);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		wb_sel_i <= s;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check("wb ack", k < 50, 32'h1);
	endtask
	task automatic power_up(input logic [3:0] p, input logic [1:0] c, input logic w);
		logic [4:0] m;
		int k;
		m = mult_of(p);
		plat_code <= p;
		core_code <= c;
		wide_pci <= w;
		low_len <= 4'($urandom_range(9));
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while ((busy !== 1'b0 || k < 2) && k < 60);
		@(negedge clock);
		check("mult", platform_mult, m);
		check("core", core_half_ratio, {1'b1, c});
		check("unsup", ratio_unsupported, m == 5'h00);
		check("pci64", pci_64bit, w);
		check("pullup", cfg_pullup_en, 32'h0);
		check("ready", {cfg_ready_oe, cfg_ready_out, ratios_valid}, 32'h7);
		wb(`STATUS_ADDR, 1'b0, 32'h0);
		check("status", q, {5'h0, 1'b1, c, 3'h0, m, 7'h0, m == 5'h00, 1'b1, w, c, p});
	endtask
	task automatic final_report();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// the whole run needs well under 2000 cycles
	initial begin
		#200000;
		n_mismatch++;
		final_report();
	end
	initial begin
		int k;
		{sys_rst, go, plat_code, core_code, wide_pci, low_len} = 13'h1000;
		{wb_adr_i, wb_dat_i, wb_we_i, wb_stb_i, wb_cyc_i} = '0;
		wb_sel_i = 4'hf;
		n_mismatch = 0;
		compares = 0;
		void'($urandom(32'hc1dc));
		repeat (15) @(posedge clock);
		@(negedge clock);
		check("reset pins", {cfg_pullup_en, cfg_ready_oe}, 32'h3);
		check("reset outs", {ratios_valid, cfg_ready_out, pci_64bit, ratio_unsupported,
			sys_ref_tick, wb_ack_o, platform_mult, core_half_ratio}, 32'h0);
		@(posedge clock);
		sys_rst <= 1'b0;
		wb(`CONTROL_ADDR, 1'b0, 32'h0);
		check("control reset", q, 32'h0);
		for (int i = 0; i < 16; i++)
			power_up(4'(i), 2'(i), 1'($urandom));
		wb(8'h0c, 1'b1, $urandom);
		wb(8'h0c, 1'b0, 32'h0);
		check("unmapped", q, 32'h0);
		wb(`CONTROL_ADDR, 1'b1, 32'h1, 4'he);
		wb(`CONTROL_ADDR, 1'b0, 32'h0);
		check("sel gate", q, 32'h0);
		power_up(4'h3, 2'h1, 1'b0);
		wb(`CONTROL_ADDR, 1'b1, 32'h1);
		k = 0;
		while (sys_ref_tick !== 1'b1 && k < 40) begin
			@(posedge clock);
			k++;
		end
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (sys_ref_tick !== 1'b1 && k < 40);
		check("tick gap", k, {27'h0, mult_of(4'h3)});
		wb(`CONTROL_ADDR, 1'b0, 32'h0);
		check("control on", q, 32'h1);
		wb(`CONTROL_ADDR, 1'b1, 32'h0);
		wb(`TICKS_ADDR, 1'b0, 32'h0);
		t = q;
		wb(`TICKS_ADDR, 1'b0, 32'h0);
		check("ticks held", q, t);
		check("ticks seen", t >= 32'h2, 32'h1);
		// mid-run reset drops the lock and turns the pull-up back on
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		@(negedge clock);
		check("mid reset", {cfg_pullup_en, cfg_ready_oe, ratios_valid, platform_mult}, 32'hc0);
		@(posedge clock);
		sys_rst <= 1'b0;
		wb(`CONTROL_ADDR, 1'b0, 32'h0);
		check("control cleared", q, 32'h0);
		power_up(4'hc, 2'h3, 1'b1);
		final_report();
	end
endmodule // tb_clock_ratio_strap_decoder
`default_nettype wire
